/* File: rtl/tscp_pkg.sv */
// Constants for the transceiver status and configuration port.
// Assumes a 200 MHz core clock; SPI pins are asynchronous to it.
package tscp_pkg;
  localparam int TSCP_WORD_W = 16;
  localparam logic [7:0] TSCP_CFG_CMD = 8'h80;
  localparam logic [15:0] TSCP_CFG_RESET = 16'h8008;
  localparam int TSCP_ST_TXRX = 15;
  localparam int TSCP_ST_POR = 14;
  localparam int TSCP_ST_OVUR = 13;
  localparam int TSCP_ST_WAKE = 12;
  localparam int TSCP_ST_EXT = 11;
  localparam int TSCP_ST_LOWV = 10;
  localparam int TSCP_ST_EMPTY = 9;
  localparam int TSCP_ST_SIG = 8;
  localparam int TSCP_ST_GOOD = 7;
  localparam int TSCP_ST_LOCK = 6;
  localparam int TSCP_ST_TGL = 5;
  localparam int TSCP_ST_SIGN = 4;
  localparam int TSCP_CFG_TXEN = 7;
  localparam int TSCP_CFG_RXEN = 6;
  localparam int TSCP_CFG_BAND_LO = 4;
  localparam int TSCP_CFG_CAP_LO = 0;
  localparam int TSCP_CLK_MHZ = 200;
  localparam int TSCP_WAKE_MIN_US = 1000;
  localparam int TSCP_WAKE_MIN_CYC = TSCP_WAKE_MIN_US * TSCP_CLK_MHZ;
  localparam int TSCP_CAL_PERIOD_S = 30;
  localparam longint TSCP_CAL_CYC = longint'(TSCP_CAL_PERIOD_S) * TSCP_CLK_MHZ * 1000000;
  localparam int TSCP_CAL_ON_CYC = 16;
endpackage : tscp_pkg

/* File: rtl/tscp_sync.sv */
// Two-flop synchroniser for asynchronous single-bit inputs.
// Assumes the destination clock is core_clk.
`timescale 1ns/10ps
`default_nettype none
module tscp_sync
#(
  parameter logic INIT = 1'b0
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : tscp_sync
`default_nettype wire

/* File: rtl/tscp_port.sv */
// Status/config SPI slave, wake timer, calibration and interrupt merge.
// Assumes SPI mode 0 and a host SCK far slower than core_clk.
//
// What this block does
// - Signal-strength bit set above digital threshold
// - Wake timer programmable from 1 ms
// - Calibrate timer at start, every 30 s
// - Wake events drive interrupt; source in status
// - Low supply below threshold raises interrupt
// - First bit zero reads, one writes
// - Bit 15 tx ready/rx threshold, FIFO-read clear
// - Bit 14 set at power-on, read-cleared
// - Bit 13 overrun/underrun, read-cleared
// - Bit 12 wake timer overflow, read-cleared
// - Bit 11 external falling edge, read-cleared
// - Bit 10 low supply, bit 9 empty
// - Bit 8 strength in rx, tuning in tx
// - Bit 7 quality, bit 6 lock
// - Bit 5 toggles per frequency-adjust cycle
// - Bit 4 sign, bits 3:0 offset
// - Config by command byte, resets 8008h
// - Config bit 7 enables tx data register
// - Config bit 6 enables rx FIFO
// - Config bits 5:4 select band
// - Config bits 3:0 select load capacitance
// - Status bits shift before FIFO bits
`timescale 1ns/10ps
`default_nettype none
module tscp_port
  import tscp_pkg::*;
#(
  parameter int WAKE_W = 32,
  parameter longint CAL_CYC = TSCP_CAL_CYC
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_select_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic host_interrupt_out_n,
  input wire logic external_wake_input_n,
  input wire logic tx_mode,
  input wire logic rx_level_above,
  input wire logic tuning_detect,
  input wire logic low_supply_detect,
  input wire logic data_quality_good,
  input wire logic clock_recovery_locked,
  input wire logic tx_ready_event,
  input wire logic rx_threshold_event,
  input wire logic buffer_read_event,
  input wire logic buffer_error_event,
  input wire logic rx_buffer_empty,
  input wire logic freq_adjust_done,
  input wire logic [4:0] freq_offset,
  input wire logic [15:0] rx_buffer_word,
  input wire logic [WAKE_W-1:0] wake_period,
  input wire logic wake_timer_enable,
  output logic tx_data_register_enable,
  output logic rx_buffer_enable,
  output logic [1:0] band_select,
  output logic [3:0] load_cap_code,
  output logic osc_force_on,
  output logic cal_strobe
);
  initial
  begin
    if (WAKE_W < 28 || CAL_CYC < 2)
      $error("tscp_port: parameters out of range");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic sel_n_s, sck_s, sdi_s, ext_n_s;
  tscp_sync #(.INIT(1'b1)) u_sel (.core_clk(core_clk), .sys_rst(sys_rst), .d(serial_select_n), .q(sel_n_s));
  tscp_sync #(.INIT(1'b0)) u_sck (.core_clk(core_clk), .sys_rst(sys_rst), .d(spi_sck), .q(sck_s));
  tscp_sync #(.INIT(1'b0)) u_sdi (.core_clk(core_clk), .sys_rst(sys_rst), .d(spi_sdi), .q(sdi_s));
  tscp_sync #(.INIT(1'b1)) u_ext (.core_clk(core_clk), .sys_rst(sys_rst), .d(external_wake_input_n), .q(ext_n_s));

  logic sck_d, ext_n_d;
  always_ff @(posedge core_clk)
  begin
    sck_d <= sys_rst ? 1'b0 : sck_s;
    ext_n_d <= sys_rst ? 1'b1 : ext_n_s;
  end
  wire sck_rise = sck_s & ~sck_d;
  wire sck_fall = ~sck_s & sck_d;
  wire ext_fall = ext_n_d & ~ext_n_s;

  // ---------------------------------------------------------------
  // Serial frame shifter
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [31:0] shift_out;
  logic is_read;
  logic status_done;
  wire active = ~sel_n_s;
  wire first_bit = active & sck_rise & (bit_cnt == 5'h00);
  wire [4:0] next_cnt = bit_cnt + 5'h01;
  wire [15:0] next_in = {shift_in[14:0], sdi_s};
  wire word_done = active & sck_rise & (bit_cnt == 5'h0F);
  wire cfg_hit = word_done & ~is_read & (next_in[15:8] == TSCP_CFG_CMD);
  wire status_sent = active & sck_fall & is_read & (bit_cnt == 5'h10) & ~status_done;

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  logic txrx_flag, por_flag, ovur_flag, wake_flag, ext_flag, tgl_flag;
  logic wake_event;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      txrx_flag <= 1'b0;
      por_flag <= 1'b1;
      ovur_flag <= 1'b0;
      wake_flag <= 1'b0;
      ext_flag <= 1'b0;
      tgl_flag <= 1'b0;
    end
    else
    begin
      txrx_flag <= (tx_mode ? tx_ready_event : rx_threshold_event) | (txrx_flag & ~buffer_read_event);
      por_flag <= por_flag & ~status_sent;
      ovur_flag <= buffer_error_event | (ovur_flag & ~status_sent);
      wake_flag <= wake_event | (wake_flag & ~status_sent);
      ext_flag <= ext_fall | (ext_flag & ~status_sent);
      tgl_flag <= tgl_flag ^ freq_adjust_done;
    end
  end

  wire sig_bit = tx_mode ? tuning_detect : rx_level_above;
  wire [15:0] status_word = {txrx_flag, por_flag, ovur_flag, wake_flag, ext_flag,
    low_supply_detect, rx_buffer_empty, sig_bit,
    data_quality_good, clock_recovery_locked,
    tgl_flag, freq_offset};

  // ---------------------------------------------------------------
  // Shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !active)
    begin
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
      shift_out <= 32'h0000_0000;
      is_read <= 1'b0;
      status_done <= 1'b0;
      spi_sdo <= 1'b0;
    end
    else
    begin
      if (sck_rise && bit_cnt != 5'h1F)
      begin
        bit_cnt <= next_cnt;
        shift_in <= next_in;
      end
      if (first_bit)
      begin
        is_read <= ~sdi_s;
        shift_out <= {status_word, rx_buffer_word};
        spi_sdo <= status_word[TSCP_WORD_W-1];
      end
      else if (sck_fall && is_read)
      begin
        shift_out <= {shift_out[30:0], 1'b0};
        spi_sdo <= shift_out[30];
      end
      if (status_sent)
        status_done <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Configuration word
  // ---------------------------------------------------------------
  logic [7:0] cfg_low;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      cfg_low <= TSCP_CFG_RESET[7:0];
    else if (cfg_hit)
      cfg_low <= next_in[7:0];
  end
  always_ff @(posedge core_clk)
  begin
    tx_data_register_enable <= cfg_low[TSCP_CFG_TXEN];
    rx_buffer_enable <= cfg_low[TSCP_CFG_RXEN];
    band_select <= cfg_low[TSCP_CFG_BAND_LO +: 2];
    load_cap_code <= cfg_low[TSCP_CFG_CAP_LO +: 4];
  end

  // ---------------------------------------------------------------
  // Wake timer and calibration
  // ---------------------------------------------------------------
  localparam int CAL_W = 40;
  logic [WAKE_W-1:0] wake_cnt;
  logic [CAL_W-1:0] cal_cnt;
  logic [4:0] cal_on;
  wire [WAKE_W-1:0] wake_min = WAKE_W'(TSCP_WAKE_MIN_CYC);
  wire [WAKE_W-1:0] wake_lim = (wake_period < wake_min) ? wake_min : wake_period;
  wire cal_due = (cal_cnt == CAL_W'(CAL_CYC - 1));
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !wake_timer_enable)
      wake_cnt <= '0;
    else
      wake_cnt <= (wake_cnt >= wake_lim - 1'b1) ? '0 : wake_cnt + 1'b1;
  end
  assign wake_event = wake_timer_enable & (wake_cnt >= wake_lim - 1'b1);
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cal_cnt <= '0;
      cal_on <= 5'(TSCP_CAL_ON_CYC);
      osc_force_on <= 1'b1;
      cal_strobe <= 1'b0;
    end
    else
    begin
      cal_cnt <= cal_due ? '0 : cal_cnt + 1'b1;
      if (cal_due)
        cal_on <= 5'(TSCP_CAL_ON_CYC);
      else if (cal_on != 5'h00)
        cal_on <= cal_on - 5'h01;
      osc_force_on <= cal_due | (cal_on > 5'h01);
      cal_strobe <= (cal_on == 5'h02);
    end
  end

  // ---------------------------------------------------------------
  // Interrupt merge
  // ---------------------------------------------------------------
  logic lowv_flag;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      lowv_flag <= 1'b0;
    else
      lowv_flag <= low_supply_detect | (lowv_flag & ~status_sent);
  end
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      host_interrupt_out_n <= 1'b1;
    else
      host_interrupt_out_n <= ~(txrx_flag | por_flag | ovur_flag | wake_flag | ext_flag
        | lowv_flag | ~ext_n_s);
  end
endmodule : tscp_port
`default_nettype wire

/* File: verif/tscp_port_props.sv */
// Checker for tscp_port: interrupt, serial output, config, calibration.
// Assumes a bind to tscp_port; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module tscp_port_props
#(
  parameter longint CAL_CYC = 2000
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic serial_select_n,
  input wire logic spi_sck,
  input wire logic spi_sdo,
  input wire logic host_interrupt_out_n,
  input wire logic external_wake_input_n,
  input wire logic tx_mode,
  input wire logic low_supply_detect,
  input wire logic tx_ready_event,
  input wire logic [1:0] band_select,
  input wire logic [3:0] load_cap_code,
  input wire logic osc_force_on,
  input wire logic cal_strobe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  longint gap;
  // Cycles since last calibration strobe
  always_ff @(posedge core_clk)
    gap <= (sys_rst || cal_strobe) ? 0 : gap + 1;
  a_irq_ext_pin: assert property (!external_wake_input_n [*5] |-> !host_interrupt_out_n)
    else $error("irq not low with wake pin low");
  a_irq_low_supply: assert property (low_supply_detect |-> ##[1:3] !host_interrupt_out_n)
    else $error("irq not low on low supply");
  a_irq_tx_ready: assert property (tx_ready_event && tx_mode |-> ##[1:3] !host_interrupt_out_n)
    else $error("irq not low on tx ready");
  a_sdo_idle_low: assert property (serial_select_n [*5] |-> !spi_sdo)
    else $error("sdo driven while deselected");
  a_cfg_hold_idle: assert property (serial_select_n [*8] |-> $stable({band_select, load_cap_code}))
    else $error("config changed outside a frame");
  a_cal_window_len: assert property ($rose(osc_force_on) |-> osc_force_on [*8] ##[1:12] !osc_force_on)
    else $error("calibration window length wrong");
  a_cal_period_max: assert property (gap <= CAL_CYC + 64)
    else $error("calibration period overrun");
  a_sdo_hold_high: assert property (!serial_select_n && spi_sck && $past(spi_sck, 4) |-> $stable(spi_sdo))
    else $error("sdo moved while clock high");
  c_cal: cover property (cal_strobe);
  c_irq: cover property ($fell(host_interrupt_out_n));
  c_cfg: cover property ($changed(band_select));
endmodule : tscp_port_props
`default_nettype wire

/* File: verif/tscp_host_model.sv */
// Host SPI master model: select, clock and data out, sdo captured.
// Assumes mode 0, MSB first, 48 ns serial clock period.
`timescale 1ns/10ps
`default_nettype none
module tscp_host_model
(
  output logic serial_select_n,
  output logic spi_sck,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  initial
  begin
    serial_select_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
  end
  // One frame of nbits clocks; clock idles low between frames
  task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [31:0] rd);
    rd = '0;
    serial_select_n = 1'b0;
    #48;
    for (int i = 0; i < nbits; i++)
    begin
      spi_sdi = cmd[31 - i];
      #24;
      spi_sck = 1'b1;
      #24;
      // Sampled late in the high phase: the first bit settles a few core cycles after the rise, later bits after the fall
      rd[31 - i] = spi_sdo;
      spi_sck = 1'b0;
    end
    #24;
    serial_select_n = 1'b1;
    spi_sdi = ~spi_sdi;
    #48;
  endtask : xfer
endmodule : tscp_host_model
`default_nettype wire

/* File: verif/tb_tscp_port.sv */
// Testbench for tscp_port: random status reads and config writes.
// Assumes the host model as SPI master and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module tb_tscp_port;
  import tscp_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_n = 1'b1;
  logic lb = 1'b0;
  logic tgl = 1'b0;
  logic s15;
  logic [4:0] ev = '0;
  logic [4:0] sk = 5'h08;
  logic [7:0] cfgv = TSCP_CFG_RESET[7:0];
  logic [27:0] lv = '0;
  logic [31:0] seed = 32'hAF9F;
  logic [31:0] r, q, rd;
  logic sel_n, sck, sdi, sdo, irq_n, txen, rxen, oscon, cal;
  logic [1:0] band;
  logic [3:0] cap;
  int bad_count = 0;
  int checked = 0;
  tscp_port #(.WAKE_W(32), .CAL_CYC(2000)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .serial_select_n(sel_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .host_interrupt_out_n(irq_n),
    .external_wake_input_n(ext_n), .tx_mode(lv[27]), .rx_level_above(lv[26]), .tuning_detect(lv[25]),
    .low_supply_detect(lv[24]), .data_quality_good(lv[23]), .clock_recovery_locked(lv[22]),
    .tx_ready_event(ev[4]), .rx_threshold_event(ev[3]), .buffer_read_event(ev[2]), .buffer_error_event(ev[1]),
    .rx_buffer_empty(lv[21]), .freq_adjust_done(ev[0]), .freq_offset(lv[20:16]), .rx_buffer_word(lv[15:0]),
    .wake_period(32'h0003_0D40), .wake_timer_enable(1'b0), .tx_data_register_enable(txen),
    .rx_buffer_enable(rxen), .band_select(band), .load_cap_code(cap), .osc_force_on(oscon), .cal_strobe(cal));
  tscp_host_model host (.serial_select_n(sel_n), .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic [31:0] exp_rd();
    return {sk, lv[24], lv[21], lv[27] ? lv[25] : lv[26], lv[23:22], tgl, lv[20:0]};
  endfunction : exp_rd
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  initial forever #2.5 core_clk = ~core_clk;
  initial
  begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("osc_force_on", 32'(1), 32'(oscon));
    chk("config", 32'(cfgv), 32'({txen, rxen, band, cap}));
    // Writes over all band codes; last one has a wrong command byte
    for (int i = 0; i < 8; i++)
    begin
      r = xs();
      q = {(i == 7) ? 8'h81 : TSCP_CFG_CMD, r[7:6], 2'(i), r[3:0], 16'h0};
      host.xfer(q, 16, rd);
      cfgv = (i == 7) ? cfgv : q[23:16];
      chk("config", 32'(cfgv), 32'({txen, rxen, band, cap}));
    end
    // Random levels and events, then a full status read
    for (int n = 0; n < 40; n++)
    begin
      r = xs();
      q = xs();
      s15 = q[0] & r[27] | q[1] & ~r[27];
      @(posedge core_clk);
      lv <= r[27:0];
      ext_n <= q[5];
      ev <= {q[0] & r[27], q[1] & ~r[27], q[2] & ~s15, q[3], q[4]};
      sk[0] = sk[0] | ext_n & ~q[5];
      sk[4] = s15 | sk[4] & ~q[2];
      sk[2] = sk[2] | q[3];
      tgl = tgl ^ q[4];
      lb = lb | r[24];
      @(posedge core_clk);
      ev <= '0;
      repeat (8) @(posedge core_clk);
      chk("irq_n", 32'(!(|sk || !ext_n || lb)), 32'(irq_n));
      q = exp_rd();
      host.xfer(32'h0, 32, rd);
      chk("status", q, rd);
      sk = sk & 5'h10;
      lb = lv[24];
    end
    tally_and_finish();
  end
endmodule : tb_tscp_port
bind tscp_port tscp_port_props #(.CAL_CYC(CAL_CYC)) props (.core_clk(core_clk), .sys_rst(sys_rst),
  .serial_select_n(serial_select_n), .spi_sck(spi_sck), .spi_sdo(spi_sdo),
  .host_interrupt_out_n(host_interrupt_out_n), .external_wake_input_n(external_wake_input_n),
  .tx_mode(tx_mode), .low_supply_detect(low_supply_detect), .tx_ready_event(tx_ready_event),
  .band_select(band_select), .load_cap_code(load_cap_code), .osc_force_on(osc_force_on), .cal_strobe(cal_strobe));
`default_nettype wire
